// File: hdl/tpt_top.v
// Purpose: tap threshold and timing qualifier with its registers
// Assumes: samples arrive as 8-bit magnitudes on the 8g scale, 0.063g/LSB,
//          with a one-cycle strobe from same-clock logic
// Notes:   register port is a simple 8-bit read/write strobe port
`timescale 1ns/10ps
`include "tpt_regs.vh"
module tpt_top (
   input  wire       I_CORE_CLK,
   input  wire       I_RESETN,
   input  wire       i_reg_wr,
   input  wire       i_reg_rd,
   input  wire [7:0] i_reg_addr,
   input  wire [7:0] i_reg_wdata,
   input  wire       i_sample_valid,
   input  wire [7:0] i_accel_x,
   input  wire [7:0] i_accel_y,
   input  wire [7:0] i_accel_z,
   input  wire [2:0] i_accel_neg,
   output reg  [7:0] o_reg_rdata,
   output reg        o_single_tap,
   output reg        o_double_tap,
   output reg  [7:0] o_tap_source
);

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg  [6:0] x_axis_threshold;
   reg  [6:0] y_axis_threshold;
   reg  [6:0] z_axis_threshold;
   reg  [7:0] width_limit_count;
   reg  [7:0] latency_count;
   reg  [7:0] second_window_count;
   reg  [7:0] filter_cfg;
   reg  [7:0] tap_cfg;
   reg  [7:0] ctrl1;
   reg  [7:0] ctrl2;

   wire       tap_lowpass_enable;
   wire       reduced_noise_select;
   wire       double_tap_abort;
   wire       event_latch_enable;
   wire [1:0] power_mode;
   wire [2:0] rate;
   assign tap_lowpass_enable   = filter_cfg[`TPT_LPF_BIT];
   assign reduced_noise_select = ctrl1[`TPT_NOISE_BIT];
   assign double_tap_abort     = tap_cfg[`TPT_ABORT_BIT];
   assign event_latch_enable   = tap_cfg[`TPT_LATCH_BIT];
   assign power_mode           = ctrl2[1:0];
   assign rate                 = ctrl1[`TPT_DR_LSB +: 3];

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         x_axis_threshold    <= `TPT_RESET_THRESH;
         y_axis_threshold    <= `TPT_RESET_THRESH;
         z_axis_threshold    <= `TPT_RESET_THRESH;
         width_limit_count   <= `TPT_RESET_BYTE;
         latency_count       <= `TPT_RESET_BYTE;
         second_window_count <= `TPT_RESET_BYTE;
         filter_cfg          <= `TPT_RESET_BYTE;
         tap_cfg             <= `TPT_RESET_BYTE;
         ctrl1               <= `TPT_RESET_BYTE;
         ctrl2               <= `TPT_RESET_BYTE;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `TPT_ADDR_THRESH_X) begin
            x_axis_threshold <= i_reg_wdata[6:0];
         end else if (i_reg_addr == `TPT_ADDR_THRESH_Y) begin
            y_axis_threshold <= i_reg_wdata[6:0];
         end else if (i_reg_addr == `TPT_ADDR_THRESH_Z) begin
            z_axis_threshold <= i_reg_wdata[6:0];
         end else if (i_reg_addr == `TPT_ADDR_WIDTH_LIMIT) begin
            width_limit_count <= i_reg_wdata;
         end else if (i_reg_addr == `TPT_ADDR_LATENCY) begin
            latency_count <= i_reg_wdata;
         end else if (i_reg_addr == `TPT_ADDR_WINDOW) begin
            second_window_count <= i_reg_wdata;
         end else if (i_reg_addr == `TPT_ADDR_FILTER_CFG) begin
            filter_cfg <= i_reg_wdata;
         end else if (i_reg_addr == `TPT_ADDR_TAP_CFG) begin
            tap_cfg <= i_reg_wdata;
         end else if (i_reg_addr == `TPT_ADDR_CTRL1) begin
            ctrl1 <= i_reg_wdata & `TPT_CTRL1_MASK;
         end else if (i_reg_addr == `TPT_ADDR_CTRL2) begin
            ctrl2 <= i_reg_wdata & `TPT_MODS_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // base tick of 0.625 ms and step selection
   // ----------------------------------------------------------------------
   localparam [31:0] BASE_FULL = `TPT_BASE_TICK_CYCLES - 1;
   localparam [15:0] BASE_LAST = BASE_FULL[15:0];
   reg  [15:0] base_cnt;
   wire        base_tick;
   assign base_tick = (base_cnt == BASE_LAST);
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN || base_tick) begin
         base_cnt <= 16'h0000;
      end else begin
         base_cnt <= base_cnt + 16'h0001;
      end
   end

   wire [9:0] width_step;
   wire [9:0] latency_step;
   tpt_step_select u_step (
      .i_rate         (rate),
      .i_mode         (power_mode),
      .i_lpf          (tap_lowpass_enable),
      .o_width_step   (width_step),
      .o_latency_step (latency_step)
   );

   // ----------------------------------------------------------------------
   // threshold compare
   // ----------------------------------------------------------------------
   function [6:0] eff_thresh;
      input [6:0] code;
      input       noise;
      begin
         // reduced noise clips the signal at 4g; above that it never fires
         eff_thresh = code;
         if (noise && code > `TPT_NOISE_CAP) begin
            eff_thresh = 7'h7f;
         end
      end
   endfunction

   function over;
      input [7:0] mag;
      input [6:0] code;
      input       noise;
      reg   [7:0] m;
      begin
         m    = (noise && mag > {1'b0, `TPT_NOISE_CAP}) ?
                {1'b0, `TPT_NOISE_CAP} : mag;
         over = (code != `TPT_RESET_THRESH) &&
                (m > {1'b0, eff_thresh(code, noise)});
      end
   endfunction

   wire [2:0] above;
   assign above[0] = over(i_accel_x, x_axis_threshold, reduced_noise_select);
   assign above[1] = over(i_accel_y, y_axis_threshold, reduced_noise_select);
   assign above[2] = over(i_accel_z, z_axis_threshold, reduced_noise_select);

   // ----------------------------------------------------------------------
   // pulse width limit: width counter started at the rising crossing
   // ----------------------------------------------------------------------
   reg        in_pulse;
   reg  [2:0] pulse_axes;
   reg  [2:0] pulse_pol;
   wire       any_above;
   wire       pulse_rise;
   wire       pulse_fall;
   wire       width_run;
   wire       width_done;
   assign any_above  = |above;
   assign pulse_rise = i_sample_valid && any_above && !in_pulse;
   assign pulse_fall = i_sample_valid && !any_above && in_pulse;

   tpt_interval u_width (
      .i_clk       (I_CORE_CLK),
      .i_resetn    (I_RESETN),
      .i_start     (pulse_rise),
      .i_base_tick (base_tick),
      .i_step      (width_step),
      .i_count     (width_limit_count),
      .o_run       (width_run),
      .o_done      (width_done)
   );
   wire pulse_ok;
   assign pulse_ok = pulse_fall && width_run;

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         in_pulse   <= 1'b0;
         pulse_axes <= 3'h0;
         pulse_pol  <= 3'h0;
      end else if (pulse_rise) begin
         in_pulse   <= 1'b1;
         pulse_axes <= above;
         pulse_pol  <= i_accel_neg & above;
      end else if (pulse_fall) begin
         in_pulse <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // tap sequencer: idle, latency, window, second pulse
   // ----------------------------------------------------------------------
   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_LATENCY = 2'h1;
   localparam [1:0] ST_WINDOW  = 2'h2;
   localparam [1:0] ST_SECOND  = 2'h3;
   reg  [1:0] state;
   reg  [1:0] next_state;
   reg        abort_hit;
   reg        start_in_lat;
   wire       lat_start;
   wire       lat_run;
   wire       lat_done;
   wire       win_start;
   wire       win_run;
   wire       win_done;
   assign lat_start = (state == ST_IDLE) && pulse_ok;
   assign win_start = (state == ST_LATENCY) && lat_done;

   tpt_interval u_latency (
      .i_clk       (I_CORE_CLK),
      .i_resetn    (I_RESETN),
      .i_start     (lat_start),
      .i_base_tick (base_tick),
      .i_step      (latency_step),
      .i_count     (latency_count),
      .o_run       (lat_run),
      .o_done      (lat_done)
   );
   tpt_interval u_window (
      .i_clk       (I_CORE_CLK),
      .i_resetn    (I_RESETN),
      .i_start     (win_start),
      .i_base_tick (base_tick),
      .i_step      (latency_step),
      .i_count     (second_window_count),
      .o_run       (win_run),
      .o_done      (win_done)
   );

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (pulse_ok) begin
               next_state = ST_LATENCY;
            end
         end
         ST_LATENCY: begin
            // pulses here are ignored; only the abort watch looks at them
            if (lat_done) begin
               next_state = abort_hit ? ST_IDLE : ST_WINDOW;
            end
         end
         ST_WINDOW: begin
            if (pulse_rise && win_run) begin
               next_state = ST_SECOND;
            end else if (win_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            // end may fall after the window, width limit still applies
            if (pulse_fall || (in_pulse && width_done)) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         state        <= ST_IDLE;
         abort_hit    <= 1'b0;
         start_in_lat <= 1'b0;
      end else begin
         state <= next_state;
         if (lat_start) begin
            abort_hit    <= 1'b0;
            start_in_lat <= 1'b0;
         end else if (state == ST_LATENCY && lat_run) begin
            if (pulse_rise) begin
               start_in_lat <= 1'b1;
            end
            if (pulse_ok && start_in_lat && double_tap_abort) begin
               abort_hit <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // events and source register
   // ----------------------------------------------------------------------
   wire single_evt;
   wire double_evt;
   wire src_read;
   wire frozen;
   assign single_evt = lat_start;
   assign double_evt = (state == ST_SECOND) && pulse_ok;
   assign src_read   = i_reg_rd && (i_reg_addr == `TPT_ADDR_TAP_SOURCE);
   assign frozen     = event_latch_enable &&
                       o_tap_source[`TPT_SRC_ACTIVE_BIT];

   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         o_single_tap <= 1'b0;
         o_double_tap <= 1'b0;
         o_tap_source <= `TPT_RESET_BYTE;
      end else begin
         o_single_tap <= single_evt;
         o_double_tap <= double_evt;
         // a new event wins over a clearing read in the same cycle
         if ((single_evt || double_evt) && (!frozen || src_read)) begin
            o_tap_source <= {1'b1, pulse_axes, double_evt, pulse_pol};
         end else if (src_read) begin
            o_tap_source <= `TPT_RESET_BYTE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         o_reg_rdata <= `TPT_RESET_BYTE;
      end else if (i_reg_rd) begin
         if (i_reg_addr == `TPT_ADDR_THRESH_X) begin
            o_reg_rdata <= {1'b0, x_axis_threshold};
         end else if (i_reg_addr == `TPT_ADDR_THRESH_Y) begin
            o_reg_rdata <= {1'b0, y_axis_threshold};
         end else if (i_reg_addr == `TPT_ADDR_THRESH_Z) begin
            o_reg_rdata <= {1'b0, z_axis_threshold};
         end else if (i_reg_addr == `TPT_ADDR_WIDTH_LIMIT) begin
            o_reg_rdata <= width_limit_count;
         end else if (i_reg_addr == `TPT_ADDR_LATENCY) begin
            o_reg_rdata <= latency_count;
         end else if (i_reg_addr == `TPT_ADDR_WINDOW) begin
            o_reg_rdata <= second_window_count;
         end else if (i_reg_addr == `TPT_ADDR_FILTER_CFG) begin
            o_reg_rdata <= filter_cfg;
         end else if (i_reg_addr == `TPT_ADDR_TAP_CFG) begin
            o_reg_rdata <= tap_cfg;
         end else if (i_reg_addr == `TPT_ADDR_TAP_SOURCE) begin
            o_reg_rdata <= o_tap_source;
         end else if (i_reg_addr == `TPT_ADDR_CTRL1) begin
            o_reg_rdata <= ctrl1;
         end else if (i_reg_addr == `TPT_ADDR_CTRL2) begin
            o_reg_rdata <= ctrl2;
         end else begin
            o_reg_rdata <= `TPT_RESET_BYTE;
         end
      end
   end
endmodule

// File: hdl/tpt_regs.vh
// Purpose: constants for the tap timing qualifier
// Assumes: registers reached by an 8-bit address/data port on the core clock
// Notes:   time steps are counted in units of a 0.625 ms base tick
//
// Notes on behaviour
// - three separate 7-bit unsigned tap thresholds, one per axis
// - usable codes 1..127, each 0.063g against a fixed 8g scale
// - with reduced noise selected, thresholds above 4g are never reached
// - a pulse starts when an axis magnitude exceeds its threshold
// - a pulse is valid only if it falls below within the width limit
// - each interval counter spans at most its time step times 255
// - filtered width step: 1.25 ms at 800 Hz, high-res 2.5, low-power 160
// - unfiltered width step: 0.625 ms at 800 Hz, high-res 0.625, LP 40
// - after a first pulse, a latency interval ignores further pulses except for the abort check
// - latency step follows rate, oversampling mode and filter enable
// - filtered latency step: 2.5 ms at 800 Hz, high-res 5, low-power 320
// - unfiltered latency step: 1.25 ms at 800 Hz, high-res 1.25, LP 80
// - second pulse must start inside the window after latency ends
// - second pulse obeys width limit; it may end after the window closes
// - window step uses the same per-rate steps as the latency counter
// - filtered or unfiltered step set follows the tap lowpass enable bit
// - all threshold fields reset to zero
// - width limit, latency and window counts reset to zero
// - with abort set, a pulse wholly inside latency suspends double tap
// - with latching, status freezes on event active; source read clears
`ifndef TPT_REGS_VH
`define TPT_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TPT_ADDR_FILTER_CFG   8'h0f
`define TPT_ADDR_TAP_CFG      8'h21
`define TPT_ADDR_TAP_SOURCE   8'h22
`define TPT_ADDR_THRESH_X     8'h23
`define TPT_ADDR_THRESH_Y     8'h24
`define TPT_ADDR_THRESH_Z     8'h25
`define TPT_ADDR_WIDTH_LIMIT  8'h26
`define TPT_ADDR_LATENCY      8'h27
`define TPT_ADDR_WINDOW       8'h28
`define TPT_ADDR_CTRL1        8'h2a
`define TPT_ADDR_CTRL2        8'h2b

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define TPT_THRESH_MASK       8'h7f
`define TPT_RESET_BYTE        8'h00
`define TPT_RESET_THRESH      7'h00
`define TPT_LPF_BIT           4
`define TPT_ABORT_BIT         7
`define TPT_LATCH_BIT         6
`define TPT_DR_LSB            3
`define TPT_NOISE_BIT         2
`define TPT_MODS_MASK         8'h03
`define TPT_CTRL1_MASK        8'h3c
`define TPT_NOISE_CAP         7'h40
`define TPT_SRC_ACTIVE_BIT    7
`define TPT_SRC_DOUBLE_BIT    3
`define TPT_SRC_AXIS_LSB      4

// ----------------------------------------------------------------------
// oversampling modes
// ----------------------------------------------------------------------
`define TPT_MODE_NORMAL       2'h0
`define TPT_MODE_LOW_POWER_LOW_NOISE_MODE         2'h1
`define TPT_MODE_HIRES        2'h2
`define TPT_MODE_LP           2'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TPT_CLK_HZ            25000000
`define TPT_BASE_TICK_US      625
`define TPT_BASE_TICK_CYCLES  ((`TPT_CLK_HZ / 1000) * `TPT_BASE_TICK_US / 1000)
`define TPT_COUNT_MAX         8'hff

`endif

// File: hdl/tpt_step_select.v
// Purpose: choose the step, in 0.625 ms base ticks, for the tap counters
// Assumes: rate code 0 is 800 Hz, 7 is 1.56 Hz
// Notes:   step values are from the step tables, as base tick multiples
`timescale 1ns/10ps
`include "tpt_regs.vh"
module tpt_step_select (
   input  wire [2:0] i_rate,
   input  wire [1:0] i_mode,
   input  wire       i_lpf,
   output wire [9:0] o_width_step,
   output wire [9:0] o_latency_step
);

   // ----------------------------------------------------------------------
   // step in base ticks for the unfiltered width limit
   // ----------------------------------------------------------------------
   function [9:0] step_raw;
      input [2:0] rate;
      input [1:0] mode;
      reg   [9:0] norm;
      begin
         case (rate)
            3'h0:    norm = 10'h001;
            3'h1:    norm = 10'h001;
            3'h2:    norm = 10'h002;
            3'h3:    norm = 10'h004;
            default: norm = 10'h008;
         endcase
         if (mode == `TPT_MODE_HIRES) begin
            step_raw = 10'h001;
         end else if (mode == `TPT_MODE_LP) begin
            case (rate)
               3'h0:    step_raw = 10'h001;
               3'h1:    step_raw = 10'h002;
               3'h2:    step_raw = 10'h004;
               3'h3:    step_raw = 10'h008;
               3'h4:    step_raw = 10'h010;
               default: step_raw = 10'h040;
            endcase
         end else if (mode == `TPT_MODE_LOW_POWER_LOW_NOISE_MODE && rate > 3'h4) begin
            step_raw = 10'h020;
         end else begin
            step_raw = norm;
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // filtered width step: doubles per rate code, except slow rates in every mode and high-res
   // ----------------------------------------------------------------------
   function [9:0] step_lpf;
      input [2:0] rate;
      input [1:0] mode;
      begin
         if (mode == `TPT_MODE_HIRES) begin
            step_lpf = (rate == 3'h0) ? 10'h002 : 10'h004;
         end else if (mode == `TPT_MODE_NORMAL && rate > 3'h4) begin
            step_lpf = 10'h020;
         end else if (mode == `TPT_MODE_LOW_POWER_LOW_NOISE_MODE && rate > 3'h4) begin
            step_lpf = 10'h080;
         end else if (mode == `TPT_MODE_LP && rate > 3'h5) begin
            step_lpf = 10'h100;
         end else if (mode == `TPT_MODE_LP && rate == 3'h5) begin
            step_lpf = 10'h080;
         end else begin
            // filtered steps double per rate code up to 50 Hz
            step_lpf = 10'h002 << rate;
         end
      end
   endfunction

   wire [9:0] width_step;
   assign width_step = i_lpf ? step_lpf(i_rate, i_mode)
                             : step_raw(i_rate, i_mode);
   // latency and window steps are twice the width step in every cell
   assign o_width_step   = width_step;
   assign o_latency_step = {width_step[8:0], 1'b0};
endmodule

// File: hdl/tpt_interval.v
// Purpose: one interval counter stepping in base ticks
// Assumes: i_start restarts it; count 0 means already expired
// Notes:   o_done is a level once the programmed count of steps has passed
`timescale 1ns/10ps
`include "tpt_regs.vh"
module tpt_interval (
   input  wire       i_clk,
   input  wire       i_resetn,
   input  wire       i_start,
   input  wire       i_base_tick,
   input  wire [9:0] i_step,
   input  wire [7:0] i_count,
   output reg        o_run,
   output wire       o_done
);
   reg [9:0] sub;
   reg [7:0] steps;

   assign o_done = ~o_run;

   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_run <= 1'b0;
         sub   <= 10'h000;
         steps <= `TPT_RESET_BYTE;
      end else if (i_start) begin
         o_run <= (i_count != `TPT_RESET_BYTE);
         sub   <= 10'h000;
         steps <= `TPT_RESET_BYTE;
      end else if (o_run && i_base_tick) begin
         if (sub + 10'h001 >= i_step) begin
            sub   <= 10'h000;
            steps <= steps + 8'h01;
            if (steps + 8'h01 >= i_count) begin
               o_run <= 1'b0;
            end
         end else begin
            sub <= sub + 10'h001;
         end
      end
   end
endmodule

// File: verification/tpt_props.sv
// Purpose: port relations of the tap timing qualifier
// Assumes: latching is tracked from writes to the tap config byte
// Notes:   bound to every tpt_top instance
`timescale 1ns/10ps
module tpt_props (
   input wire       I_CORE_CLK,
   input wire       I_RESETN,
   input wire       i_reg_wr,
   input wire       i_reg_rd,
   input wire [7:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire       i_sample_valid,
   input wire [7:0] o_reg_rdata,
   input wire       o_single_tap,
   input wire       o_double_tap,
   input wire [7:0] o_tap_source
);
   reg  latch_on;
   wire held;
   // a latched, active source may legally ignore a new double event
   assign held = latch_on && o_tap_source[7];
   always @(posedge I_CORE_CLK) begin
      if (!I_RESETN) begin
         latch_on <= 1'b0;
      end else if (i_reg_wr && i_reg_addr == 8'h21) begin
         latch_on <= i_reg_wdata[6];
      end
   end
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESETN);
   AST_RESET: assert property ($rose(I_RESETN) |->
      o_tap_source == 8'h00 && o_reg_rdata == 8'h00 && !o_single_tap)
      else $error("outputs not clear after reset");
   AST_THR_MSB: assert property (i_reg_rd && i_reg_addr >= 8'h23 &&
      i_reg_addr <= 8'h25 |=> !o_reg_rdata[7]) else $error("msb set");
   AST_SINGLE_CAUSE: assert property (o_single_tap |->
      $past(i_sample_valid)) else $error("single tap without sample");
   AST_DOUBLE_CAUSE: assert property (o_double_tap |->
      $past(i_sample_valid) && (o_tap_source[3] || $past(held)))
      else $error("double tap without sample or flag");
   AST_SINGLE_SRC: assert property (o_single_tap |->
      o_tap_source[7] && !o_double_tap) else $error("single tap source");
   AST_PULSE: assert property (o_single_tap |=> !o_single_tap)
      else $error("single tap longer than one cycle");
   AST_RDATA_HOLD: assert property (!$past(i_reg_rd) &&
      $past(I_RESETN) |-> $stable(o_reg_rdata))
      else $error("read data moved");
   AST_SRC_CLEAR: assert property (i_reg_rd && i_reg_addr == 8'h22 &&
      !i_sample_valid |=> o_tap_source == 8'h00)
      else $error("source not cleared by read");
endmodule
bind tpt_top tpt_props u_props (.*);

// File: verification/tpt_host.sv
// Purpose: host processor model on the register port
// Assumes: strobes launched 1 ns after an edge, one cycle each
// Notes:   read data taken 1 ns after the edge at which the strobe is seen
`timescale 1ns/10ps
module tpt_host (
   input  wire       I_CORE_CLK,
   input  wire [7:0] o_reg_rdata,
   output reg        i_reg_wr = 1'b0,
   output reg        i_reg_rd = 1'b0,
   output reg  [7:0] i_reg_addr = 8'h00,
   output reg  [7:0] i_reg_wdata = 8'h00
);
   task wr_reg(input [7:0] a, input [7:0] d);
      @(posedge I_CORE_CLK);
      #1;
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(posedge I_CORE_CLK);
      #1;
      i_reg_wr = 1'b0;
   endtask
   task rd_reg(input [7:0] a, output [7:0] d);
      @(posedge I_CORE_CLK);
      #1;
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      @(posedge I_CORE_CLK);
      #1;
      i_reg_rd = 1'b0;
      d = o_reg_rdata;
   endtask
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the tap timing qualifier
// Assumes: 800 Hz unfiltered steps, base tick of 15625 cycles
// Notes:   latency mostly zero so the run stays short
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
   reg        I_CORE_CLK = 1'b0;
   reg        I_RESETN = 1'b0;
   reg        i_sample_valid = 1'b0;
   reg  [7:0] i_accel_x = 8'h00, i_accel_y = 8'h00, i_accel_z = 8'h00;
   reg  [2:0] i_accel_neg = 3'h0;
   wire       i_reg_wr, i_reg_rd, o_single_tap, o_double_tap;
   wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_tap_source;
   integer    mismatches = 0;
   integer    checks = 0;
   integer    k;
   reg  [7:0] rd;
   reg [23:0] rows [0:6];
   tpt_host host (.*);
   tpt_top DUT (.*);
   initial forever #20 I_CORE_CLK = ~I_CORE_CLK;
   initial begin
      #(90000 * 40);
      mismatches++;
      conclude;
   end
   task conclude;
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task smp(input [1:0] ax, input [7:0] mag, input neg);
      @(posedge I_CORE_CLK);
      #1;
      i_sample_valid = 1'b1;
      i_accel_x = (ax == 2'd0) ? mag : 8'h00;
      i_accel_y = (ax == 2'd1) ? mag : 8'h00;
      i_accel_z = (ax == 2'd2) ? mag : 8'h00;
      i_accel_neg = {2'b00, neg} << ax;
      @(posedge I_CORE_CLK);
      #1;
      i_sample_valid = 1'b0;
   endtask
   task tap(input [1:0] ax, input neg, input s, input d, input [7:0] src);
      smp(ax, 8'hff, neg);
      smp(ax, 8'h00, neg);
      `CHK("single", s, o_single_tap)
      `CHK("double", d, o_double_tap)
      `CHK("source", src, o_tap_source)
   endtask
   initial begin
      // addr, written, read back; latency set before any tap use
      rows = '{24'h23ff7f, 24'h248000, 24'h25c141, 24'h26a5a5,
               24'h270000, 24'h280202, 24'h441200};
      repeat (3) @(posedge I_CORE_CLK);
      #1;
      I_RESETN = 1'b1;
      for (k = 0; k < 7; k++) begin
         host.rd_reg(rows[k][23:16], rd);
         `CHK("reset value", 8'h00, rd)
         host.wr_reg(rows[k][23:16], rows[k][15:8]);
         host.rd_reg(rows[k][23:16], rd);
         `CHK("read back", rows[k][7:0], rd)
      end
      // reduced noise clips at 0x40, so code 0x41 is out of reach
      host.wr_reg(8'h2a, 8'h04);
      host.wr_reg(8'h23, 8'h41);
      tap(2'd0, 1'b0, 1'b0, 1'b0, 8'h00);
      host.wr_reg(8'h23, 8'h3f);
      tap(2'd0, 1'b1, 1'b1, 1'b0, 8'h91);
      tap(2'd0, 1'b1, 1'b0, 1'b1, 8'h99);
      host.rd_reg(8'h22, rd);
      `CHK("source read", 8'h99, rd)
      `CHK("source cleared", 8'h00, o_tap_source)
      host.wr_reg(8'h28, 8'h01);
      host.wr_reg(8'h24, 8'h10);
      tap(2'd1, 1'b1, 1'b1, 1'b0, 8'ha2);
      repeat (31260) @(posedge I_CORE_CLK);
      tap(2'd1, 1'b0, 1'b1, 1'b0, 8'ha0);
      // mid-run reset puts registers and sequencer back to rest
      @(posedge I_CORE_CLK);
      #1;
      I_RESETN = 1'b0;
      @(posedge I_CORE_CLK);
      #1;
      I_RESETN = 1'b1;
      `CHK("reset source", 8'h00, o_tap_source)
      host.rd_reg(8'h26, rd);
      `CHK("reset width", 8'h00, rd)
      // pulse held past one width step must not count
      host.wr_reg(8'h23, 8'h3f);
      host.wr_reg(8'h26, 8'h01);
      smp(2'd0, 8'hff, 1'b0);
      repeat (15630) @(posedge I_CORE_CLK);
      smp(2'd0, 8'h00, 1'b0);
      `CHK("late release", 1'b0, o_single_tap)
      `CHK("late double", 1'b0, o_double_tap)
      // latched source keeps the first event until it is read
      host.wr_reg(8'h26, 8'h10);
      host.wr_reg(8'h21, 8'h40);
      tap(2'd0, 1'b0, 1'b1, 1'b0, 8'h90);
      tap(2'd0, 1'b1, 1'b1, 1'b0, 8'h90);
      host.rd_reg(8'h22, rd);
      `CHK("latched read", 8'h90, rd)
      // abort: a pulse wholly inside latency drops the double tap
      host.wr_reg(8'h21, 8'h80);
      host.wr_reg(8'h27, 8'h01);
      host.wr_reg(8'h28, 8'h02);
      tap(2'd0, 1'b0, 1'b1, 1'b0, 8'h90);
      tap(2'd0, 1'b1, 1'b0, 1'b0, 8'h90);
      repeat (31260) @(posedge I_CORE_CLK);
      tap(2'd0, 1'b1, 1'b1, 1'b0, 8'h91);
      conclude;
   end
endmodule
